// File: verilog/tcc_timer_channel.sv
// Purpose: timer channel two with pin io control, capture and compare
// Assumes: classic wishbone slave, 32-bit data, single clock
// Notes: counter advances every clock; there are no external count source inputs
// Operation
// - 8-bit pin control, B high, A low
// - top bit 0: compare, initial level, 00 off
// - compare 01: drive low on match
// - compare 10: drive high on match
// - compare 11: toggle on match
// - top bit 1: capture own pin, rising
// - capture 01: falling edge
// - capture 1x: both edges, bit 2 ignored
// - enable bit gates converter start requests
// - flags clear only by writing zero
// - up/down only phase or cascade, else up
// - mode decode; reserved top bit reads zero
// - counter clear none, A, B, sync
//
// Local design decision: the Wishbone register port.
module tcc_timer_channel
  import tcc_pkg::*;
#(
  parameter int CountWidth = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pinAIn,
  output logic pinAOut,
  output logic pinAOutEnable,
  input wire logic pinBIn,
  output logic pinBOut,
  output logic pinBOutEnable,
  input wire logic phaseDown,
  input wire logic syncClear,
  output logic adcStart,
  output logic irq
);
  logic [7:0] pinControl;
  logic [7:0] timerControl;
  logic [7:0] timerMode;
  logic [7:0] intEnable;
  logic [7:0] status;
  logic [7:0] mask;
  logic [CountWidth-1:0] count;
  logic [CountWidth-1:0] generalA;
  logic [CountWidth-1:0] generalB;
  logic [1:0] pinMeta;
  logic [1:0] pinSync;
  logic [1:0] dirMeta;
  logic dirSync;
  logic syncMeta;
  logic syncSync;
  logic wbWrite;
  logic wbRead;
  logic pinWritten;
  logic matchA;
  logic matchB;
  logic capA;
  logic capB;
  logic eventA;
  logic eventB;
  logic clearCount;
  logic countDown;
  logic wrap;
  logic pinAOutW;
  logic pinAEnW;
  logic pinBOutW;
  logic pinBEnW;
  tcc_mode_type mode;
  logic [7:0] next_status;

  function automatic logic hit(input logic [15:0] adr, input logic [15:0] off);
    hit = adr == off;
  endfunction

  function automatic logic [7:0] laneByte(input logic [31:0] d, input logic [1:0] lane);
    laneByte = d[8*lane +: 8];
  endfunction

  assign wbWrite = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign wbRead = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // pins come from outside: two flops before any use
  always_ff @(posedge clk) begin
    if (srst) begin
      pinMeta <= 2'h0;
      pinSync <= 2'h0;
      dirMeta <= 2'h0;
      dirSync <= 1'b0;
      syncMeta <= 1'b0;
      syncSync <= 1'b0;
    end else begin
      pinMeta <= {pinBIn, pinAIn};
      pinSync <= pinMeta;
      dirMeta <= {dirMeta[0], phaseDown};
      dirSync <= dirMeta[1];
      syncMeta <= syncClear;
      syncSync <= syncMeta;
    end
  end

  always_comb begin
    case (timerMode[2:0])
      3'h0: mode = TCC_NORMAL;
      3'h2: mode = TCC_PWM1;
      3'h3: mode = TCC_PWM2;
      3'h4, 3'h5, 3'h6, 3'h7: mode = TCC_PHASE;
      default: mode = TCC_UNUSED;
    endcase
  end

  // single register write, byte sel on lane 0
  always_ff @(posedge clk) begin
    if (srst) begin
      pinControl <= TCC_PINIO_RESET;
      timerControl <= TCC_CTRL_RESET;
      timerMode <= TCC_MODE_RESET;
      intEnable <= TCC_ENABLE_RESET;
      mask <= TCC_MASK_RESET;
      pinWritten <= 1'b0;
    end else begin
      pinWritten <= 1'b0;
      if (wbWrite && wb_sel_i[0]) begin
        if (hit(wb_adr_i, TCC_OFF_PINIO)) begin
          pinControl <= laneByte(wb_dat_i, 2'h0);
          pinWritten <= 1'b1;
        end
        if (hit(wb_adr_i, TCC_OFF_CTRL)) begin
          timerControl <= laneByte(wb_dat_i, 2'h0);
        end
        if (hit(wb_adr_i, TCC_OFF_MODE)) begin
          // reserved top mode bit always held at zero
          timerMode <= {2'h3, 2'h0, 1'b0, wb_dat_i[2:0]};
        end
        if (hit(wb_adr_i, TCC_OFF_ENABLE)) begin
          intEnable <= laneByte(wb_dat_i, 2'h0);
        end
        if (hit(wb_adr_i, TCC_OFF_MASK)) begin
          mask <= laneByte(wb_dat_i, 2'h0) & TCC_STATUS_MASK;
        end
      end
    end
  end

  assign matchA = count == generalA;
  assign matchB = count == generalB;
  assign eventA = capA | (matchA & ~pinControl[TCC_FLD_CAP]);
  assign eventB = capB | (matchB & ~pinControl[4 + TCC_FLD_CAP]);

  always_comb begin
    case (timerControl[TCC_CCLR_LSB +: 2])
      TCC_CCLR_A: clearCount = eventA;
      TCC_CCLR_B: clearCount = eventB;
      TCC_CCLR_SYNC: clearCount = syncSync;
      default: clearCount = 1'b0;
    endcase
  end

  // down counting only in phase mode or cascade; else forced up
  assign countDown = (mode == TCC_PHASE || timerControl[TCC_DIR_BIT]) && dirSync;
  assign wrap = countDown ? (count == '0) : (count == '1);

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= TCC_COUNT_RESET;
    end else if (wbWrite && hit(wb_adr_i, TCC_OFF_COUNT)) begin
      count <= wb_dat_i[CountWidth-1:0];
    end else if (clearCount) begin
      count <= '0;
    end else if (countDown) begin
      count <= count - 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end

  // capture beats a software write in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      generalA <= TCC_GR_RESET;
      generalB <= TCC_GR_RESET;
    end else begin
      if (capA) begin
        generalA <= count;
      end else if (wbWrite && hit(wb_adr_i, TCC_OFF_GRA)) begin
        generalA <= wb_dat_i[CountWidth-1:0];
      end
      if (capB) begin
        generalB <= count;
      end else if (wbWrite && hit(wb_adr_i, TCC_OFF_GRB)) begin
        generalB <= wb_dat_i[CountWidth-1:0];
      end
    end
  end

  tcc_channel_pin pinAPath (
    .clk(clk),
    .srst(srst),
    .field(pinControl[3:0]),
    .fieldWritten(pinWritten),
    .countMatch(matchA),
    .pinSync(pinSync[0]),
    .pinOut(pinAOutW),
    .pinOutEnable(pinAEnW),
    .captureEvent(capA)
  );

  tcc_channel_pin pinBPath (
    .clk(clk),
    .srst(srst),
    .field(pinControl[7:4]),
    .fieldWritten(pinWritten),
    .countMatch(matchB),
    .pinSync(pinSync[1]),
    .pinOut(pinBOutW),
    .pinOutEnable(pinBEnW),
    .captureEvent(capB)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      pinAOut <= 1'b0;
      pinAOutEnable <= 1'b1;
      pinBOut <= 1'b0;
      pinBOutEnable <= 1'b1;
    end else begin
      pinAOut <= pinAOutW;
      pinAOutEnable <= pinAEnW;
      pinBOut <= pinBOutW;
      pinBOutEnable <= pinBEnW;
    end
  end

  // set wins over a written zero in the same cycle
  always_comb begin
    next_status = status;
    if (wbWrite && wb_sel_i[0] && hit(wb_adr_i, TCC_OFF_STATUS)) begin
      next_status = status & wb_dat_i[7:0];
    end
    next_status[TCC_ST_MATCH_A] = next_status[TCC_ST_MATCH_A] | eventA;
    next_status[TCC_ST_MATCH_B] = next_status[TCC_ST_MATCH_B] | eventB;
    next_status[TCC_ST_OVF] = next_status[TCC_ST_OVF] | (wrap & ~countDown & ~clearCount);
    next_status[TCC_ST_UNF] = next_status[TCC_ST_UNF] | (wrap & countDown & ~clearCount);
    next_status = next_status & TCC_STATUS_MASK;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status <= 8'h00;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & mask);
    end
  end

  // converter start on A event, only when enabled
  always_ff @(posedge clk) begin
    if (srst) begin
      adcStart <= 1'b0;
    end else begin
      adcStart <= intEnable[TCC_EN_ADC] & eventA;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= (wbWrite | wbRead);
      wb_dat_o <= 32'h0000_0000;
      if (wbRead) begin
        case (wb_adr_i)
          TCC_OFF_CTRL: wb_dat_o <= {24'h000000, timerControl};
          TCC_OFF_MODE: wb_dat_o <= {24'h000000, timerMode};
          TCC_OFF_PINIO: wb_dat_o <= {24'h000000, pinControl};
          TCC_OFF_ENABLE: wb_dat_o <= {24'h000000, intEnable};
          TCC_OFF_STATUS: wb_dat_o <= {24'h000000, status};
          TCC_OFF_COUNT: wb_dat_o <= {16'h0000, count};
          TCC_OFF_GRA: wb_dat_o <= {16'h0000, generalA};
          TCC_OFF_GRB: wb_dat_o <= {16'h0000, generalB};
          TCC_OFF_MASK: wb_dat_o <= {24'h000000, mask};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // tcc_timer_channel

// File: pkg/tcc_pkg.sv
// Purpose: constants for the channel-two capture/compare timer block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: offsets are byte addresses on the register bus
package tcc_pkg;
  localparam logic [15:0] TCC_OFF_CTRL = 16'hFFF0;
  localparam logic [15:0] TCC_OFF_MODE = 16'hFFF1;
  localparam logic [15:0] TCC_OFF_PINIO = 16'hFFF2;
  localparam logic [15:0] TCC_OFF_ENABLE = 16'hFFF4;
  localparam logic [15:0] TCC_OFF_STATUS = 16'hFFF5;
  localparam logic [15:0] TCC_OFF_COUNT = 16'hFFF6;
  localparam logic [15:0] TCC_OFF_GRA = 16'hFFF8;
  localparam logic [15:0] TCC_OFF_GRB = 16'hFFFA;
  localparam logic [15:0] TCC_OFF_MASK = 16'hFFFC;
  localparam logic [7:0] TCC_PINIO_RESET = 8'h00;
  localparam logic [7:0] TCC_CTRL_RESET = 8'h00;
  localparam logic [7:0] TCC_MODE_RESET = 8'hC0;
  localparam logic [7:0] TCC_ENABLE_RESET = 8'h00;
  localparam logic [7:0] TCC_MASK_RESET = 8'h00;
  localparam logic [15:0] TCC_GR_RESET = 16'hFFFF;
  localparam logic [15:0] TCC_COUNT_RESET = 16'h0000;
  // status bit positions
  localparam int TCC_ST_MATCH_A = 0;
  localparam int TCC_ST_MATCH_B = 1;
  localparam int TCC_ST_OVF = 4;
  localparam int TCC_ST_UNF = 5;
  localparam logic [7:0] TCC_STATUS_MASK = 8'h33;
  // field positions
  localparam int TCC_FLD_CAP = 3;
  localparam int TCC_FLD_INIT = 2;
  localparam int TCC_EN_ADC = 7;
  localparam int TCC_CCLR_LSB = 5;
  localparam int TCC_DIR_BIT = 4;
  localparam int TCC_MODE_RSV = 3;
  localparam logic [1:0] TCC_ACT_NONE = 2'h0;
  localparam logic [1:0] TCC_ACT_LOW = 2'h1;
  localparam logic [1:0] TCC_ACT_HIGH = 2'h2;
  localparam logic [1:0] TCC_ACT_TOGGLE = 2'h3;
  localparam logic [1:0] TCC_CCLR_NONE = 2'h0;
  localparam logic [1:0] TCC_CCLR_A = 2'h1;
  localparam logic [1:0] TCC_CCLR_B = 2'h2;
  localparam logic [1:0] TCC_CCLR_SYNC = 2'h3;
  typedef enum {TCC_NORMAL, TCC_PWM1, TCC_PWM2, TCC_PHASE, TCC_UNUSED} tcc_mode_type;
endpackage

// File: verilog/tcc_channel_pin.sv
// Purpose: one compare/capture pin path for a general register
// Assumes: pin input already synchronised to clk
// Notes: field is the 4-bit io control nibble
module tcc_channel_pin
  import tcc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] field,
  input wire logic fieldWritten,
  input wire logic countMatch,
  input wire logic pinSync,
  output logic pinOut,
  output logic pinOutEnable,
  output logic captureEvent
);
  logic pinLast;
  logic isCapture;
  logic rise;
  logic fall;

  assign isCapture = field[TCC_FLD_CAP];
  assign rise = pinSync & ~pinLast;
  assign fall = ~pinSync & pinLast;

  always_ff @(posedge clk) begin
    if (srst) begin
      pinLast <= 1'b0;
    end else begin
      pinLast <= pinSync;
    end
  end

  // bit 2 ignored when capturing; bit 1 set means both edges
  always_ff @(posedge clk) begin
    if (srst) begin
      captureEvent <= 1'b0;
    end else if (!isCapture) begin
      captureEvent <= 1'b0;
    end else if (field[1]) begin
      captureEvent <= rise | fall;
    end else if (field[0]) begin
      captureEvent <= fall;
    end else begin
      captureEvent <= rise;
    end
  end

  // enable is active low: low while driving
  always_ff @(posedge clk) begin
    if (srst) begin
      pinOut <= 1'b0;
      pinOutEnable <= 1'b1;
    end else if (isCapture || field[1:0] == TCC_ACT_NONE) begin
      pinOutEnable <= 1'b1;
    end else if (fieldWritten) begin
      pinOut <= field[TCC_FLD_INIT];
      pinOutEnable <= 1'b0;
    end else if (countMatch) begin
      pinOutEnable <= 1'b0;
      case (field[1:0])
        TCC_ACT_LOW: pinOut <= 1'b0;
        TCC_ACT_HIGH: pinOut <= 1'b1;
        TCC_ACT_TOGGLE: pinOut <= ~pinOut;
        default: pinOut <= pinOut;
      endcase
    end
  end
endmodule // tcc_channel_pin

// File: dv/tcc_checker.sv
// Purpose: port checks for the timer channel
// Assumes: one clock, srst sync active high
// Notes: pin checks lean on the two-flop output path
module tcc_checker
  import tcc_pkg::*;
#(
  parameter int CountWidth = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pinAOut,
  input wire logic pinAOutEnable,
  input wire logic pinBOutEnable,
  input wire logic adcStart,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence reqTaken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence pinWrite;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == TCC_OFF_PINIO;
  endsequence
  a_ack_next: assert property (reqTaken |=> wb_ack_o)
    else $error("request without ack");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_mode_fixed: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == TCC_OFF_MODE |-> wb_dat_o[7:6] == 2'h3 && !wb_dat_o[3])
    else $error("mode fixed bits wrong");
  a_reset_outputs: assert property ($fell(srst) |->
    pinAOutEnable && pinBOutEnable && !irq && !adcStart) else $error("outputs after reset");
  a_initial_level: assert property (
    pinWrite ##0 (!wb_dat_i[3] && wb_dat_i[1:0] != 2'h0)
    |-> ##3 (!pinAOutEnable && pinAOut == $past(wb_dat_i[2], 3)))
    else $error("initial level not shown");
  a_capture_released: assert property (pinWrite ##0 wb_dat_i[7] |-> ##3 pinBOutEnable)
    else $error("capture pin still driven");
  a_adc_single: assert property (adcStart |=> !adcStart)
    else $error("start request too long");
endmodule // tcc_checker
bind tcc_timer_channel tcc_checker #(.CountWidth(CountWidth)) chk_u (.clk, .srst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .pinAOut,
  .pinAOutEnable, .pinBOutEnable, .adcStart, .irq);

// File: dv/tcc_pin_model.sv
// Purpose: outside drivers on the two channel pins
// Assumes: enable low means the channel drives
// Notes: no keeper, released pin shows the bench level
module tcc_pin_model (
  input wire logic levelA,
  input wire logic levelB,
  input wire logic pinAOut,
  input wire logic pinAOutEnable,
  input wire logic pinBOut,
  input wire logic pinBOutEnable,
  output logic pinA,
  output logic pinB
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pinA = pinAOutEnable ? levelA : pinAOut;
  assign pinB = pinBOutEnable ? levelB : pinBOut;
endmodule // tcc_pin_model

// File: dv/timer_ch2_io_compare_capture_test.sv
// Purpose: self-checking bench for the channel-two timer
// Assumes: ack one cycle after a taken request
// Notes: counter free runs, so checks use windows
module timer_ch2_io_compare_capture_test
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0, rdat, datO;
  logic [3:0] sel = 4'h0;
  logic lvlA = 1'b0, lvlB = 1'b0, down = 1'b0, sclr = 1'b0;
  logic ack, aOut, aOe, bOut, bOe, pinA, pinB, adcStart, irq;
  int errors = 0, num_checks = 0, adcCnt = 0;
  always #20 clk = ~clk;
  always @(posedge clk) if (adcStart === 1'b1) adcCnt++;
  tcc_timer_channel #(.CountWidth(16)) dut_u (.clk(clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(datO), .wb_ack_o(ack), .pinAIn(pinA), .pinAOut(aOut), .pinAOutEnable(aOe),
    .pinBIn(pinB), .pinBOut(bOut), .pinBOutEnable(bOe), .phaseDown(down),
    .syncClear(sclr), .adcStart(adcStart), .irq(irq));
  tcc_pin_model pins_u (.levelA(lvlA), .levelB(lvlB), .pinAOut(aOut), .pinAOutEnable(aOe),
    .pinBOut(bOut), .pinBOutEnable(bOe), .pinA(pinA), .pinB(pinB));
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  // bounded wait: a silent slave ends the run
  task automatic bus(logic w, logic [15:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      finish_test();
    end
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic drive(logic b, logic v);
    if (b) lvlB <= v;
    else lvlA <= v;
  endtask
  task automatic t_regs();
    bus(1'b0, TCC_OFF_PINIO, 32'h0);
    check("pin control reset", 32'h0, rdat);
    bus(1'b0, TCC_OFF_MODE, 32'h0);
    check("mode reset", 32'hC0, rdat);
    bus(1'b1, TCC_OFF_MODE, 32'hFF);
    bus(1'b0, TCC_OFF_MODE, 32'h0);
    check("mode reserved bit", 32'hC7, rdat);
    bus(1'b1, TCC_OFF_MODE, 32'h0);
    bus(1'b1, TCC_OFF_PINIO, 32'hA5);
    bus(1'b0, TCC_OFF_PINIO, 32'h0);
    check("pin control rw", 32'hA5, rdat);
    bus(1'b0, 16'hFFF3, 32'h0);
    check("unmapped read", 32'h0, rdat);
  endtask
  task automatic t_cmp(logic b, logic [1:0] act, logic init);
    logic [3:0] fld;
    logic expLvl;
    fld = {1'b0, init, act};
    expLvl = act == 2'h3 ? !init : act[1];
    bus(1'b1, b ? TCC_OFF_GRB : TCC_OFF_GRA, 32'h8000);
    bus(1'b1, TCC_OFF_PINIO, b ? {24'h0, fld, 4'h0} : {28'h0, fld});
    tick(4);
    check("output enable", act == 2'h0, b ? bOe : aOe);
    if (act != 2'h0)
      check("initial level", init, b ? bOut : aOut);
    bus(1'b1, TCC_OFF_COUNT, 32'h7FF0);
    tick(24);
    if (act != 2'h0)
      check("match level", expLvl, b ? bOut : aOut);
  endtask
  task automatic t_cap(logic b, logic [3:0] m);
    bus(1'b1, TCC_OFF_COUNT, 32'h0100);
    bus(1'b1, TCC_OFF_PINIO, b ? {24'h0, m, 4'h0} : {28'h0, m});
    for (int e = 0; e < 2; e++) begin
      drive(b, e[0]);
      tick(8);
      bus(1'b1, b ? TCC_OFF_GRB : TCC_OFF_GRA, 32'h0);
      drive(b, !e[0]);
      tick(8);
      bus(1'b0, b ? TCC_OFF_GRB : TCC_OFF_GRA, 32'h0);
      check("capture", m[1] || m[0] == e[0], rdat != 32'h0);
    end
  endtask
  task automatic t_irq();
    bus(1'b1, TCC_OFF_PINIO, 32'h08);
    bus(1'b1, TCC_OFF_MASK, 32'h0);
    drive(1'b0, 1'b0);
    tick(8);
    bus(1'b1, TCC_OFF_STATUS, 32'h0);
    drive(1'b0, 1'b1);
    tick(8);
    check("irq masked", 1'b0, irq);
    bus(1'b1, TCC_OFF_MASK, 32'h01);
    tick(2);
    check("irq raised", 1'b1, irq);
    bus(1'b1, TCC_OFF_STATUS, 32'hFF);
    tick(2);
    check("irq after one", 1'b1, irq);
    bus(1'b1, TCC_OFF_STATUS, 32'hFE);
    bus(1'b0, TCC_OFF_STATUS, 32'h0);
    check("flag cleared", 32'h0, rdat & 32'h1);
    check("irq cleared", 1'b0, irq);
    bus(1'b1, TCC_OFF_STATUS, 32'hFF);
    bus(1'b0, TCC_OFF_STATUS, 32'h0);
    check("flag not set by one", 32'h0, rdat & 32'h1);
  endtask
  task automatic t_adc(logic en);
    int c0;
    bus(1'b1, TCC_OFF_ENABLE, {24'h0, en, 7'h0});
    drive(1'b0, 1'b0);
    tick(8);
    c0 = adcCnt;
    drive(1'b0, 1'b1);
    tick(8);
    check("start requests", en, adcCnt - c0);
  endtask
  // direction request goes first: it crosses three sync flops
  task automatic t_dir(logic [7:0] md, logic [7:0] ctl, logic dn);
    down <= 1'b1;
    bus(1'b1, TCC_OFF_MODE, {24'h0, md});
    bus(1'b1, TCC_OFF_CTRL, {24'h0, ctl});
    bus(1'b1, TCC_OFF_COUNT, 32'h0100);
    tick(4);
    bus(1'b0, TCC_OFF_COUNT, 32'h0);
    check("count direction", dn, rdat[15:0] < 16'h0100);
    down <= 1'b0;
    tick(1);
  endtask
  // short period: without the clear the count runs far past the match value
  task automatic t_clr();
    bus(1'b1, TCC_OFF_GRA, 32'h0010);
    bus(1'b1, TCC_OFF_PINIO, 32'h0);
    bus(1'b1, TCC_OFF_CTRL, 32'h20);
    bus(1'b1, TCC_OFF_COUNT, 32'h0);
    tick(40);
    bus(1'b0, TCC_OFF_COUNT, 32'h0);
    check("clear on a match", 1'b1, rdat[15:0] <= 16'h0010);
    bus(1'b1, TCC_OFF_GRB, 32'h0010);
    bus(1'b1, TCC_OFF_CTRL, 32'h40);
    tick(40);
    bus(1'b0, TCC_OFF_COUNT, 32'h0);
    check("clear on b match", 1'b1, rdat[15:0] <= 16'h0010);
    sclr <= 1'b1;
    bus(1'b1, TCC_OFF_CTRL, 32'h60);
    tick(4);
    bus(1'b0, TCC_OFF_COUNT, 32'h0);
    check("sync clear", 32'h0, rdat);
    sclr <= 1'b0;
    bus(1'b1, TCC_OFF_CTRL, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    for (int i = 0; i < 8; i++) t_cmp(1'b0, i[1:0], i[2]);
    t_cmp(1'b1, 2'h3, 1'b0);
    t_cmp(1'b1, 2'h2, 1'b0);
    t_cmp(1'b1, 2'h1, 1'b1);
    t_cap(1'b0, 4'h8);
    t_cap(1'b0, 4'h9);
    t_cap(1'b0, 4'hA);
    t_cap(1'b0, 4'hF);
    t_cap(1'b1, 4'hC);
    t_cap(1'b1, 4'hB);
    t_irq();
    t_adc(1'b0);
    t_adc(1'b1);
    t_dir(8'h04, 8'h00, 1'b1);
    t_dir(8'h00, 8'h00, 1'b0);
    t_dir(8'h00, 8'h10, 1'b1);
    t_clr();
    finish_test();
  end
endmodule // timer_ch2_io_compare_capture_test
